// ---- design/hbsc_pkg.sv ----
package hbsc_pkg;
  localparam int          CW              = 16;
  localparam int          NSW             = 6;
  localparam int          SYNC_W          = 19;
  localparam int          CNT_W           = 18;
  localparam int          BIT_CLEAR       = 0;
  localparam int          BIT_LOW1        = 3;
  localparam int          SW_PAIR         = 2;
  localparam int          SW_STRIDE       = 4;
  localparam int          BIT_OLC_N       = 13;
  localparam int          BIT_DELAY       = 14;
  localparam int          BIT_SWEN        = 15;
  localparam int          BIT_PREWARN     = 0;
  localparam int          BIT_SHORT       = 13;
  localparam int          BIT_EN          = 14;
  localparam int          BIT_SUPPLY      = 15;
  localparam logic [15:0] CTRL_RESET      = 16'hE000;
  localparam logic [15:0] USED_MASK       = 16'hF999;
  localparam logic [15:0] OT_WORD         = 16'hFFFF;
  localparam logic [4:0]  FRAME_BITS      = 5'h10;
  localparam int          CLK_MHZ         = 20;
  localparam int          DELAY_LONG_US   = 12000;
  localparam int          DELAY_SHORT_US  = 1500;
  localparam int          DELAY_LONG_CYC  = DELAY_LONG_US * CLK_MHZ;
  localparam int          DELAY_SHORT_CYC = DELAY_SHORT_US * CLK_MHZ;

  // switch index to control and status bit position
  function automatic int sw_pos(input int idx);
    return BIT_LOW1 + SW_STRIDE * (idx / SW_PAIR) + (idx % SW_PAIR);
  endfunction
endpackage

// ---- design/hbsc_sync.sv ----
`timescale 1ns/1ps
module hbsc_sync #(
  parameter int               W    = 1,
  parameter logic [W-1:0]     INIT = '0
) (
  input  wire logic           ref_clk_in,
  input  wire logic           rst_in,
  input  wire logic [W-1:0]   async_in,
  output logic      [W-1:0]   sync_out
);
  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stage1   <= INIT;
      sync_out <= INIT;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ---- design/hbsc_short_timer.sv ----
`timescale 1ns/1ps
module hbsc_short_timer #(
  parameter int                         LONG_CYC  = hbsc_pkg::DELAY_LONG_CYC,
  parameter int                         SHORT_CYC = hbsc_pkg::DELAY_SHORT_CYC
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  input  wire logic [hbsc_pkg::NSW-1:0] over_current_in,
  input  wire logic                     long_sel_in,
  input  wire logic                     clear_in,
  output logic      [hbsc_pkg::NSW-1:0] short_off_out
);
  localparam int W = hbsc_pkg::CNT_W;

  wire  [W-1:0]             limit_m1 = long_sel_in ? W'(LONG_CYC - 1) : W'(SHORT_CYC - 1);
  logic [hbsc_pkg::NSW-1:0] trip;

  genvar g;
  generate
    for (g = 0; g < hbsc_pkg::NSW; g++) begin : g_ch
      logic [W-1:0] cnt;
      assign trip[g] = over_current_in[g] & (cnt == limit_m1);
      always_ff @(posedge ref_clk_in) begin
        if (rst_in || !over_current_in[g]) begin
          cnt <= '0;
        end else if (cnt != limit_m1) begin
          cnt <= cnt + W'(1);
        end
      end
      // latch off, clear re-enables, set wins
      always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
          short_off_out[g] <= 1'h0;
        end else if (trip[g]) begin
          short_off_out[g] <= 1'h1;
        end else if (clear_in) begin
          short_off_out[g] <= 1'h0;
        end
      end
    end
  endgenerate

  property p_trip_latch;
    @(posedge ref_clk_in) disable iff (rst_in)
    (trip != '0) |=> ((short_off_out & $past(trip)) == $past(trip));
  endproperty
  a_trip_latch: assert property (p_trip_latch) else $error("trip not latched");

  property p_clear_all;
    @(posedge ref_clk_in) disable iff (rst_in)
    (clear_in && trip == '0) |=> (short_off_out == '0);
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("short not cleared");
endmodule

// ---- design/hbsc_serial_ctrl.sv ----
`timescale 1ns/1ps
module hbsc_serial_ctrl #(
  parameter int                         LONG_CYC  = hbsc_pkg::DELAY_LONG_CYC,
  parameter int                         SHORT_CYC = hbsc_pkg::DELAY_SHORT_CYC
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     chip_select_n_in,
  input  wire logic                     serial_clk_in,
  input  wire logic                     serial_in_in,
  input  wire logic                     hw_enable_in,
  input  wire logic                     thermal_prewarn_in,
  input  wire logic                     over_temp_in,
  input  wire logic                     under_voltage_in,
  input  wire logic [hbsc_pkg::NSW-1:0] over_current_in,
  input  wire logic [hbsc_pkg::NSW-1:0] open_load_in,
  output logic                          serial_out_out,
  output logic                          serial_out_oe_n_out,
  output logic                          low_drive_1_out,
  output logic                          high_drive_1_out,
  output logic                          low_drive_2_out,
  output logic                          high_drive_2_out,
  output logic                          low_drive_3_out,
  output logic                          high_drive_3_out,
  output logic                          open_load_check_n_out,
  output logic                          short_delay_select_out
);
  localparam int                       NSW     = hbsc_pkg::NSW;
  localparam int                       CW      = hbsc_pkg::CW;
  localparam int                       SYNC_W  = hbsc_pkg::SYNC_W;
  localparam logic [SYNC_W-1:0]        PIN_INIT = {1'h1, {(SYNC_W - 1){1'h0}}};

  logic [SYNC_W-1:0] pin_s;
  logic              cs_s;
  logic              sclk_s;
  logic              sin_s;
  logic              hwen_s;
  logic              tp_s;
  logic              ot_s;
  logic              uv_s;
  logic [NSW-1:0]    oc_s;
  logic [NSW-1:0]    ol_s;

  logic              cs_q;
  logic              sclk_q;
  logic [4:0]        bit_cnt;
  logic [CW-1:0]     in_shift;
  logic [CW-1:0]     out_shift;
  logic [CW-1:0]     control_word;
  logic              supply_fail_flag;
  logic              ot_latched;
  logic [NSW-1:0]    drive_on;
  logic [NSW-1:0]    drive_req;
  logic [NSW-1:0]    next_drive;
  logic [NSW-1:0]    short_off;
  logic [NSW-1:0]    status_sw;
  logic [NSW-1:0]    stat_pick;
  logic [CW-1:0]     status_base;
  logic [CW-1:0]     status_word;

  // pins and analog detector levels are all asynchronous
  hbsc_sync #(
    .W    (SYNC_W),
    .INIT (PIN_INIT)
  ) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({chip_select_n_in, serial_clk_in, serial_in_in, hw_enable_in,
                  thermal_prewarn_in, over_temp_in, under_voltage_in,
                  over_current_in, open_load_in}),
    .sync_out   (pin_s)
  );

  assign {cs_s, sclk_s, sin_s, hwen_s, tp_s, ot_s, uv_s, oc_s, ol_s} = pin_s;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cs_q   <= 1'h1;
      sclk_q <= 1'h0;
    end else begin
      cs_q   <= cs_s;
      sclk_q <= sclk_s;
    end
  end

  wire cs_fall    = cs_q & ~cs_s;
  wire cs_rise    = ~cs_q & cs_s;
  wire sck_rise   = ~sclk_q & sclk_s & ~cs_s & ~cs_fall;
  wire sck_fall   = sclk_q & ~sclk_s & ~cs_s & ~cs_fall;
  wire frame_full = (bit_cnt == hbsc_pkg::FRAME_BITS);
  wire apply      = cs_rise & frame_full;
  wire clear_cmd  = apply & in_shift[hbsc_pkg::BIT_CLEAR];
  wire enable_eff = control_word[hbsc_pkg::BIT_SWEN] & hwen_s;
  wire olc_on     = ~control_word[hbsc_pkg::BIT_OLC_N];
  wire out_next   = out_shift[1];
  wire stat_first = status_word[hbsc_pkg::BIT_PREWARN];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cs_fall) begin
      bit_cnt <= '0;
    end else if (sck_fall && !frame_full) begin
      bit_cnt <= bit_cnt + 5'h1;
    end
  end

  // lsb arrives first, lands at bit 0 after sixteen
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      in_shift <= '0;
    end else if (sck_fall) begin
      in_shift <= {sin_s, in_shift[CW-1:1]};
    end
  end

  // lsb first; advance on clock rise
  // first rise before any fall keeps bit 0, host may idle clock low
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      out_shift <= '0;
    end else if (cs_fall) begin
      out_shift <= status_word;
    end else if (sck_rise && bit_cnt != '0) begin
      out_shift <= {1'h0, out_shift[CW-1:1]};
    end
  end

  assign serial_out_out = out_shift[0];

  // drive on select, release on deselect
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cs_s) begin
      serial_out_oe_n_out <= 1'h1;
    end else if (cs_fall) begin
      serial_out_oe_n_out <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      control_word <= hbsc_pkg::CTRL_RESET;
    end else if (apply) begin
      control_word <= in_shift & hbsc_pkg::USED_MASK;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      supply_fail_flag <= 1'h0;
    end else if (uv_s) begin
      supply_fail_flag <= 1'h1;
    end else if (clear_cmd) begin
      supply_fail_flag <= 1'h0;
    end
  end

  // shutdown held until cleared after cooling
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ot_latched <= 1'h0;
    end else if (ot_s) begin
      ot_latched <= 1'h1;
    end else if (clear_cmd) begin
      ot_latched <= 1'h0;
    end
  end

  hbsc_short_timer #(
    .LONG_CYC  (LONG_CYC),
    .SHORT_CYC (SHORT_CYC)
  ) u_timer (
    .ref_clk_in      (ref_clk_in),
    .rst_in          (rst_in),
    .over_current_in (oc_s & drive_on),
    .long_sel_in     (control_word[hbsc_pkg::BIT_DELAY]),
    .clear_in        (clear_cmd),
    .short_off_out   (short_off)
  );

  genvar g;
  generate
    for (g = 0; g < NSW; g++) begin : g_sw
      assign drive_req[g]  = control_word[hbsc_pkg::sw_pos(g)];
      assign next_drive[g] = drive_req[g] & enable_eff & ~short_off[g] & ~ot_latched & ~uv_s;
      assign status_sw[g]  = olc_on ? ol_s[g] : drive_on[g];
      assign stat_pick[g]  = status_word[hbsc_pkg::sw_pos(g)];
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      drive_on <= '0;
    end else begin
      drive_on <= next_drive;
    end
  end

  assign low_drive_1_out  = drive_on[0];
  assign high_drive_1_out = drive_on[1];
  assign low_drive_2_out  = drive_on[2];
  assign high_drive_2_out = drive_on[3];
  assign low_drive_3_out  = drive_on[4];
  assign high_drive_3_out = drive_on[5];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      open_load_check_n_out  <= 1'h1;
      short_delay_select_out <= 1'h1;
    end else begin
      open_load_check_n_out  <= control_word[hbsc_pkg::BIT_OLC_N];
      short_delay_select_out <= control_word[hbsc_pkg::BIT_DELAY];
    end
  end

  always_comb begin
    status_base                        = '0;
    status_base[hbsc_pkg::BIT_PREWARN] = tp_s;
    for (int i = 0; i < NSW; i++) begin
      status_base[hbsc_pkg::sw_pos(i)] = status_sw[i];
    end
    status_base[hbsc_pkg::BIT_SHORT]   = |short_off;
    status_base[hbsc_pkg::BIT_EN]      = enable_eff;
    status_base[hbsc_pkg::BIT_SUPPLY]  = supply_fail_flag;
  end

  assign status_word = ot_latched ? hbsc_pkg::OT_WORD : status_base;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_full_end;
    cs_rise && frame_full;
  endsequence

  sequence s_clear_write;
    s_full_end ##0 in_shift[hbsc_pkg::BIT_CLEAR] ##0 (!uv_s && !ot_s);
  endsequence

  sequence s_open;
    cs_fall ##1 !serial_out_oe_n_out;
  endsequence

  property p_open;
    cs_fall |-> s_open;
  endproperty
  a_open: assert property (p_open) else $error("output not enabled");

  property p_hiz;
    cs_s |=> serial_out_oe_n_out;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while idle");

  property p_first_bit;
    cs_fall |=> serial_out_out == $past(stat_first);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("bit 0 not first");

  property p_hold;
    (!sck_rise && !cs_fall) |=> $stable(serial_out_out);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved off rise");

  property p_step;
    (sck_rise && bit_cnt != '0) |=> serial_out_out == $past(out_next);
  endproperty
  a_step: assert property (p_step) else $error("output did not step");

  property p_sample;
    sck_fall |=> in_shift[CW-1] == $past(sin_s);
  endproperty
  a_sample: assert property (p_sample) else $error("input not sampled");

  property p_apply;
    s_full_end |=> control_word == ($past(in_shift) & hbsc_pkg::USED_MASK);
  endproperty
  a_apply: assert property (p_apply) else $error("control not applied");

  property p_abort;
    (cs_rise && !frame_full) |=> $stable(control_word);
  endproperty
  a_abort: assert property (p_abort) else $error("short frame applied");

  property p_ctrl_hold;
    !apply |=> $stable(control_word);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed early");

  property p_reset_word;
    $fell(rst_in) |-> control_word == hbsc_pkg::CTRL_RESET;
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("bad reset word");

  property p_clear;
    s_clear_write |=> (!supply_fail_flag && !ot_latched);
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");

  property p_supply;
    uv_s |=> supply_fail_flag ##1 (supply_fail_flag || $past(clear_cmd));
  endproperty
  a_supply: assert property (p_supply) else $error("supply flag missing");

  property p_ot_word;
    ot_latched |-> status_word == hbsc_pkg::OT_WORD;
  endproperty
  a_ot_word: assert property (p_ot_word) else $error("shutdown word wrong");

  property p_en_stat;
    !ot_latched |-> status_word[hbsc_pkg::BIT_EN] == enable_eff;
  endproperty
  a_en_stat: assert property (p_en_stat) else $error("enable status wrong");

  property p_standby;
    !enable_eff |=> drive_on == '0;
  endproperty
  a_standby: assert property (p_standby) else $error("driver on in standby");

  property p_switch;
    (enable_eff && !ot_latched && !uv_s && short_off == '0) |=> drive_on == $past(drive_req);
  endproperty
  a_switch: assert property (p_switch) else $error("driver map wrong");

  property p_ol_stat;
    (!ot_latched && olc_on) |-> stat_pick == ol_s;
  endproperty
  a_ol_stat: assert property (p_ol_stat) else $error("open-load status wrong");

  property p_unused;
    !ot_latched |-> (status_word & ~hbsc_pkg::USED_MASK) == '0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
endmodule

// ---- testbench/hbsc_host.sv ----
`timescale 1ns/1ps
module hbsc_host (
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      sdi_out,
  input  wire logic sdo_in
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out  = 1'b0;
  end

  // status is read at each fall, half a period after the rise moved it
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    #17;
    // select fall opens, early rise aborts
    cs_n_out = 1'b0;
    #400;
    for (int k = 0; k < 16; k++) begin
      if (k < nbits) begin
        // bit 0 first, stable round fall
        sdi_out  = word[k];
        sclk_out = 1'b1;
        #200;
        // read on the fall, the rise has settled it
        rx[k]    = sdo_in;
        sclk_out = 1'b0;
        #200;
      end
    end
    if (nbits == 0) rx[0] = sdo_in;
    // pull-down level once released
    sdi_out  = 1'b0;
    cs_n_out = 1'b1;
  endtask
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  localparam int LONG_CYC  = 40;
  localparam int SHORT_CYC = 10;
  localparam int LIMIT     = 30000;
  logic        clk, rst, cs_n, sclk, sdi, hw_en, prewarn, ot, uv, sdo, oe_n, olc_n, dsel;
  logic [5:0]  oc, ol, drv, m_soff;
  logic [15:0] m_ctrl, w;
  logic        m_supply, m_short, m_ot;
  wire         sdo_wire;
  int          bad_count, n_tests, nb;
  int          cycles = 0;
  int          pos[6] = '{3, 4, 7, 8, 11, 12};

  // released line floats, so a read without drive never matches
  assign sdo_wire = oe_n ? 1'bz : sdo;

  hbsc_serial_ctrl #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) i_hbsc_serial_ctrl (
    .ref_clk_in(clk), .rst_in(rst), .chip_select_n_in(cs_n), .serial_clk_in(sclk),
    .serial_in_in(sdi), .hw_enable_in(hw_en), .thermal_prewarn_in(prewarn),
    .over_temp_in(ot), .under_voltage_in(uv), .over_current_in(oc), .open_load_in(ol),
    .serial_out_out(sdo), .serial_out_oe_n_out(oe_n), .low_drive_1_out(drv[0]),
    .high_drive_1_out(drv[1]), .low_drive_2_out(drv[2]), .high_drive_2_out(drv[3]),
    .low_drive_3_out(drv[4]), .high_drive_3_out(drv[5]), .open_load_check_n_out(olc_n),
    .short_delay_select_out(dsel)
  );

  hbsc_host i_hbsc_host (.cs_n_out(cs_n), .sclk_out(sclk), .sdi_out(sdi), .sdo_in(sdo_wire));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [5:0] m_drv();
    logic [5:0] d;
    for (int i = 0; i < 6; i++) begin
      d[i] = m_ctrl[pos[i]] & m_ctrl[15] & hw_en & ~uv & ~m_ot & ~m_soff[i];
    end
    return d;
  endfunction

  function automatic logic [15:0] m_stat();
    logic [15:0] s;
    logic [5:0]  d;
    d    = m_drv();
    s    = 16'h0000;
    s[0] = prewarn;
    for (int i = 0; i < 6; i++) begin
      s[pos[i]] = m_ctrl[13] ? d[i] : ol[i];
    end
    s[13] = m_short;
    s[14] = m_ctrl[15] & hw_en;
    s[15] = m_supply;
    if (m_ot) s = 16'hFFFF;
    return s;
  endfunction

  task automatic miss(input logic [15:0] got, input logic [15:0] exp);
    bad_count++;
    $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
  endtask

  task automatic chk_status(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) miss(got, exp);
  endtask

  task automatic chk_pins();
    logic [8:0] got, exp;
    got = {oe_n, dsel, olc_n, drv};
    exp = {1'b1, m_ctrl[14], m_ctrl[13], m_drv()};
    n_tests++;
    if (got !== exp) miss({7'h00, got}, {7'h00, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic frame(input logic [15:0] wd, input int nbits);
    logic [15:0] rx, exp, msk;
    exp = m_stat();
    msk = (nbits == 0) ? 16'h0001 : 16'hFFFF >> (16 - nbits);
    i_hbsc_host.xfer(wd, nbits, rx);
    chk_status(rx & msk, exp & msk);
    if (nbits >= 16) begin
      if (wd[0]) begin
        m_supply = uv;
        m_short  = 1'b0;
        m_soff   = 6'h00;
        if (!ot) m_ot = 1'b0;
      end
      m_ctrl = wd & 16'hF999;
    end
    settle(10);
    chk_pins();
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      final_report();
    end
  end

  initial begin
    rst = 1'b1; hw_en = 1'b1; prewarn = 1'b0; ot = 1'b0; uv = 1'b0; oc = 6'h00; ol = 6'h00;
    bad_count = 0; n_tests = 0;
    m_ctrl = 16'hE000; m_supply = 1'b0; m_short = 1'b0; m_ot = 1'b0; m_soff = 6'h00;
    void'($urandom(16702));
    settle(6);
    rst = 1'b0;
    settle(4);
    chk_pins();
    // prewarn read alone, then an aborted nine-bit frame
    prewarn = 1'b1;
    settle(4);
    frame(16'h9998, 0);
    frame(16'h9999, 9);
    prewarn = 1'b0;
    // each switch alone, unused bits written high
    for (int i = 0; i < 6; i++) begin
      frame(16'hA666 | (16'h0001 << pos[i]) | ((i % 2) ? 16'h4000 : 16'h0000), 16);
    end
    frame(16'h3998, 16);
    hw_en = 1'b0;
    frame(16'hB998, 16);
    hw_en = 1'b1;
    settle(4);
    frame(16'hB998, 16);
    // short delay setting, SHORT_CYC of 10 cycles here, then clear re-enables
    frame(16'hA008, 16);
    oc = 6'h01;
    settle(60);
    oc = 6'h00; m_soff[0] = 1'b1; m_short = 1'b1;
    settle(4);
    chk_pins();
    frame(16'hA008, 16);
    frame(16'hA009, 16);
    // long delay setting outlasts the short one
    frame(16'hE010, 16);
    oc = 6'h02;
    settle(25);
    chk_pins();
    settle(40);
    oc = 6'h00; m_soff[1] = 1'b1; m_short = 1'b1;
    settle(4);
    chk_pins();
    frame(16'hE011, 16);
    // supply fail is sticky until cleared
    frame(16'hA018, 16);
    uv = 1'b1; m_supply = 1'b1;
    settle(6);
    chk_pins();
    uv = 1'b0;
    settle(6);
    chk_pins();
    frame(16'hA018, 16);
    frame(16'hA019, 16);
    // thermal shutdown holds until cooled and cleared
    ot = 1'b1; m_ot = 1'b1;
    settle(6);
    chk_pins();
    frame(16'hA018, 16);
    frame(16'hA019, 16);
    ot = 1'b0;
    frame(16'hA019, 16);
    frame(16'hA018, 16);
    // random words, detectors and short frames
    repeat (14) begin
      w       = 16'($urandom);
      nb      = ($urandom % 4 == 0) ? int'($urandom % 16) : 16;
      ol      = 6'($urandom);
      prewarn = 1'($urandom);
      hw_en   = 1'($urandom % 4 != 0);
      settle(4);
      frame(w, nb);
    end
    final_report();
  end
endmodule
